// [sip_pkg.sv]
package sip_pkg;

  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SAFETY = 8'h04;
  localparam logic [7:0] REG_IN_WORD = 8'h08;
  localparam logic [7:0] REG_OUT_WORD = 8'h0C;
  localparam logic [7:0] REG_OUT_SEL = 8'h10;
  localparam logic [7:0] REG_BUS_CMD = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_STRAP = 8'h1C;

  // Interface modes
  typedef enum logic [1:0] {
    SIP_MODE_STRAP = 2'h0,
    SIP_MODE_FREE = 2'h1,
    SIP_MODE_FIXED = 2'h2
  } sip_mode_t;
  localparam logic [1:0] SIP_MODE_ILLEGAL = 2'h3;

  // Startup sequencer
  typedef enum logic [2:0] {
    SIP_ST_SETTLE = 3'b001,
    SIP_ST_SAMPLE = 3'b010,
    SIP_ST_RUN = 3'b100
  } sip_state_t;
  localparam logic [1:0] SETTLE_CYC = 2'h2;

  // Baud and profile codes
  localparam logic [2:0] CAN_BAUD_MAX = 3'h5;
  localparam logic [2:0] RS485_BAUD_MAX = 3'h3;
  localparam logic [1:0] PROF_PLAIN = 2'h0;
  localparam logic [1:0] PROF_OPEN = 2'h1;
  localparam logic [1:0] PROF_DNET = 2'h2;

  // Safety input indices and reset values
  localparam int SAFE_POSITIVE_TRAVEL_LIMIT = 0;
  localparam int SAFE_NEGATIVE_TRAVEL_LIMIT = 1;
  localparam int SAFE_STOP = 2;
  localparam int SAFE_REF = 3;
  localparam logic [3:0] SAFE_EN_RST = 4'h7;
  localparam logic [3:0] SAFE_POL_RST = 4'h0;

  // Input and output words
  localparam int OUT_N = 5;
  localparam int IN_N = 14;
  localparam logic [4:0] OUT_WORD_RST = 5'h00;
  localparam logic [4:0] OUT_SEL_RST = 5'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OUT_HOLD_NS = 500000;
  localparam int OUT_HOLD_CYC = (OUT_HOLD_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int SLOW_DIV_CYC = 16;

  typedef struct packed {
    logic bus_can;
    logic prof_hi;
    logic prof_lo;
    logic qstop;
    logic lim_n;
    logic lim_p;
    logic ref_sw;
    logic adr64;
    logic cap_b;
    logic cap_a;
    logic [2:0] baud;
    logic [5:0] adr;
  } sip_pins_t;

  typedef struct packed {
    logic [3:0] pol;
    logic [3:0] en;
  } sip_safety_t;

  typedef struct packed {
    logic teach;
    logic fclr;
    logic enable;
    logic auto_sel;
    logic fast;
    logic jog_n;
    logic jog_p;
  } sip_bus_cmd_t;

  typedef struct packed {
    logic fb_active;
    logic baud_err;
    logic ref_act;
    logic abort;
    logic fault;
    logic finished;
    logic auto_ack;
  } sip_status_t;

  typedef struct packed {
    logic sampled;
    logic can;
    logic [1:0] profile;
    logic [2:0] baud;
    logic [6:0] addr;
  } sip_strap_t;

  typedef struct packed {
    logic jog_pos;
    logic jog_neg;
    logic jog_fast;
    logic auto_mode;
    logic amp_enable;
    logic fault_clear;
    logic teach_store;
    logic motion_abort;
    logic ref_active;
    logic capture_a;
    logic capture_b;
    logic capture_fast;
    logic [5:0] list_sel;
  } sip_motion_t;

  typedef struct packed {
    logic motion_end;
    logic motion_fault;
    logic motion_info;
    logic drive_ready;
  } sip_core_t;

endpackage

// [sip_top.sv]
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Mode 0 samples straps at power-up
// - Seven straps give binary station address 0-127
// - Decode baud code per fitted bus
// - Reserved baud blocks fieldbus, flags error
// - Two profile straps select bus profile
// - Mode 1 lets bus assign general I/O
// - Input word readable, output word drives pins
// - Mode 2 gives pins fixed functions
// - Jog pins move motor, speed select
// - Auto pin selects mode, confirm output
// - Enable pin switches power amplifier
// - Fault clear and teach store inputs
// - Fast capture sampling only in mode 0
// - Limits or quick-stop abort motion immediately
// - Safety inputs configurable, default active low
// - Reference switch disabled by default
// - Outputs hold each level 0.5 ms
// - Bus data carries manual and auto functions
// - Finished and fault outputs in mode 2
module sip_top #(
  parameter int HOLD_CYC = sip_pkg::OUT_HOLD_CYC,
  parameter int SLOW_DIV = sip_pkg::SLOW_DIV_CYC,
  parameter logic [1:0] IO_MODE_RST = 2'h0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [sip_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sip_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [sip_pkg::DATA_W-1:0] reg_rdata,
  // Signal interface pins
  input wire sip_pkg::sip_pins_t pins_in,
  output logic [sip_pkg::OUT_N-1:0] q_pins,
  // Motion core
  input wire sip_pkg::sip_core_t core_in,
  output sip_pkg::sip_motion_t motion_out,
  output sip_pkg::sip_strap_t strap_out,
  output logic fieldbus_active,
  output logic fieldbus_cfg_error
);
  import sip_pkg::*;

  localparam int HCW = 17;
  localparam int SCW = 8;
  localparam logic [HCW-1:0] HOLD_LOAD = HCW'(HOLD_CYC);
  localparam logic [SCW-1:0] SLOW_LAST = SCW'(SLOW_DIV - 1);

  // Pin synchroniser
  sip_pins_t pins_m_q, pins_s_q, pins_p_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pins_m_q <= '0;
      pins_s_q <= '0;
      pins_p_q <= '0;
    end else begin
      pins_m_q <= pins_in;
      pins_s_q <= pins_m_q;
      pins_p_q <= pins_s_q;
    end
  end

  // Registers
  logic [1:0] mode_q;
  sip_safety_t safety_q;
  logic [OUT_N-1:0] out_word_q, out_sel_q;
  sip_bus_cmd_t bus_cmd_q;
  logic bus_fclr_q, bus_teach_q;
  sip_strap_t strap_q;
  sip_state_t state_q;
  logic [1:0] settle_q;
  logic fault_q;
  logic [DATA_W-1:0] rdata_q;
  sip_motion_t motion_q;
  logic [SCW-1:0] slow_cnt_q;
  logic cap_a_slow_q, cap_b_slow_q;

  wire logic wr_ctrl = reg_we && (reg_addr == REG_CTRL);
  wire logic wr_safety = reg_we && (reg_addr == REG_SAFETY);
  wire logic wr_out_word = reg_we && (reg_addr == REG_OUT_WORD);
  wire logic wr_out_sel = reg_we && (reg_addr == REG_OUT_SEL);
  wire logic wr_bus_cmd = reg_we && (reg_addr == REG_BUS_CMD);
  wire sip_bus_cmd_t wr_cmd = sip_bus_cmd_t'(reg_wdata[6:0]);
  wire logic mode_ok = reg_wdata[1:0] != SIP_MODE_ILLEGAL;

  wire logic is_fixed = mode_q == SIP_MODE_FIXED;
  wire logic is_free = mode_q == SIP_MODE_FREE;
  wire logic is_strap = mode_q == SIP_MODE_STRAP;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= IO_MODE_RST;
      safety_q <= {SAFE_POL_RST, SAFE_EN_RST};
      out_word_q <= OUT_WORD_RST;
      out_sel_q <= OUT_SEL_RST;
      bus_cmd_q <= '0;
      bus_fclr_q <= 1'b0;
      bus_teach_q <= 1'b0;
    end else begin
      if (wr_ctrl && mode_ok)
        mode_q <= reg_wdata[1:0];
      if (wr_safety)
        safety_q <= sip_safety_t'(reg_wdata[7:0]);
      if (wr_out_word)
        out_word_q <= reg_wdata[OUT_N-1:0];
      if (wr_out_sel)
        out_sel_q <= reg_wdata[OUT_N-1:0];
      if (wr_bus_cmd)
        bus_cmd_q <= wr_cmd;
      bus_fclr_q <= wr_bus_cmd && wr_cmd.fclr;
      bus_teach_q <= wr_bus_cmd && wr_cmd.teach;
    end
  end

  // Power-up strap capture: let the synchroniser fill, sample once
  wire logic baud_bad = pins_s_q.bus_can ?
      (pins_s_q.baud > CAN_BAUD_MAX) :
      (pins_s_q.baud > RS485_BAUD_MAX);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SIP_ST_SETTLE;
      settle_q <= '0;
      strap_q <= '0;
    end else begin
      unique case (state_q)
        SIP_ST_SETTLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == SETTLE_CYC)
            state_q <= SIP_ST_SAMPLE;
        end
        SIP_ST_SAMPLE: begin
          state_q <= SIP_ST_RUN;
          if (is_strap) begin
            strap_q.addr <= {pins_s_q.adr64, pins_s_q.adr};
            strap_q.baud <= pins_s_q.baud;
            strap_q.profile <= {pins_s_q.prof_hi, pins_s_q.prof_lo};
            strap_q.can <= pins_s_q.bus_can;
            strap_q.sampled <= 1'b1;
          end
        end
        SIP_ST_RUN: begin
          state_q <= SIP_ST_RUN;
        end
      endcase
    end
  end

  wire logic strap_baud_bad = strap_q.can ?
      (strap_q.baud > CAN_BAUD_MAX) :
      (strap_q.baud > RS485_BAUD_MAX);
  wire logic strap_prof_bad = strap_q.can &&
      (strap_q.profile > PROF_DNET);
  wire logic cfg_err = strap_q.sampled &&
      (strap_baud_bad || strap_prof_bad);
  wire logic fb_on = strap_q.sampled && !cfg_err;

  // Safety inputs: active when enabled and level equals polarity
  wire logic [3:0] safe_raw = {pins_s_q.ref_sw, pins_s_q.qstop,
                               pins_s_q.lim_n, pins_s_q.lim_p};
  wire logic [3:0] safe_act = safety_q.en &
                              ~(safe_raw ^ safety_q.pol);
  wire logic abort = safe_act[SAFE_POSITIVE_TRAVEL_LIMIT] || safe_act[SAFE_NEGATIVE_TRAVEL_LIMIT] ||
                     safe_act[SAFE_STOP];

  // Command sources: pins in fixed mode, bus data otherwise
  wire logic src_jog_p = is_fixed ? pins_s_q.baud[0] : bus_cmd_q.jog_p;
  wire logic src_jog_n = is_fixed ? pins_s_q.baud[1] : bus_cmd_q.jog_n;
  wire logic src_fast = is_fixed ? pins_s_q.baud[2] : bus_cmd_q.fast;
  wire logic src_auto = is_fixed ? pins_s_q.prof_hi : bus_cmd_q.auto_sel;
  wire logic src_en = is_fixed ? pins_s_q.prof_lo : bus_cmd_q.enable;
  wire logic fclr_rise = pins_s_q.cap_a && !pins_p_q.cap_a;
  wire logic teach_rise = pins_s_q.adr64 && !pins_p_q.adr64;
  wire logic src_fclr = is_fixed ? fclr_rise : bus_fclr_q;
  wire logic src_teach = is_fixed ? teach_rise : bus_teach_q;

  // Capture inputs: every cycle in mode 0, divided sampling in mode 1, and for B only in mode 2
  wire logic slow_tick = slow_cnt_q == SLOW_LAST;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slow_cnt_q <= '0;
      cap_a_slow_q <= 1'b0;
      cap_b_slow_q <= 1'b0;
    end else begin
      slow_cnt_q <= slow_tick ? '0 : slow_cnt_q + 8'h01;
      if (slow_tick) begin
        cap_a_slow_q <= pins_s_q.cap_a;
        cap_b_slow_q <= pins_s_q.cap_b;
      end
    end
  end
  wire logic cap_a_v = is_strap ? pins_s_q.cap_a : cap_a_slow_q;
  wire logic cap_b_v = is_strap ? pins_s_q.cap_b : cap_b_slow_q;

  sip_motion_t motion_d;
  always_comb begin
    motion_d = '0;
    motion_d.jog_pos = src_jog_p && !abort;
    motion_d.jog_neg = src_jog_n && !abort;
    motion_d.jog_fast = src_fast;
    motion_d.auto_mode = src_auto;
    motion_d.amp_enable = src_en;
    motion_d.fault_clear = src_fclr;
    motion_d.teach_store = src_teach;
    motion_d.motion_abort = abort;
    motion_d.ref_active = safe_act[SAFE_REF];
    motion_d.capture_a = is_fixed ? 1'b0 : cap_a_v;
    motion_d.capture_b = cap_b_v;
    motion_d.capture_fast = is_strap;
    motion_d.list_sel = is_fixed ? pins_s_q.adr : 6'h00;
  end

  // Fault indication: a new fault wins over a clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      motion_q <= '0;
      fault_q <= 1'b0;
    end else begin
      motion_q <= motion_d;
      if (core_in.motion_fault)
        fault_q <= 1'b1;
      else if (src_fclr)
        fault_q <= 1'b0;
    end
  end

  // Output pins: fixed functions or output word, with minimum hold
  wire logic [OUT_N-1:0] fixed_fn = {core_in.drive_ready, fault_q,
                                     core_in.motion_end,
                                     core_in.motion_info,
                                     motion_q.auto_mode};
  wire logic [OUT_N-1:0] free_fn = (out_sel_q & fixed_fn) |
                                   (~out_sel_q & out_word_q);
  wire logic [OUT_N-1:0] q_target = is_fixed ? fixed_fn : free_fn;
  logic [OUT_N-1:0] q_out_q;
  logic [HCW-1:0] hold_q [OUT_N];

  genvar gi;
  generate
    for (gi = 0; gi < OUT_N; gi++) begin : g_out
      wire logic may_change = hold_q[gi] == '0;
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          q_out_q[gi] <= 1'b0;
          hold_q[gi] <= '0;
        end else if (may_change && (q_target[gi] != q_out_q[gi])) begin
          q_out_q[gi] <= q_target[gi];
          hold_q[gi] <= HOLD_LOAD;
        end else if (!may_change) begin
          hold_q[gi] <= hold_q[gi] - 17'h00001;
        end
      end
      property p_out_hold;
        @(posedge mclk) disable iff (!nrst)
        (hold_q[gi] != '0) |=> $stable(q_out_q[gi]);
      endproperty
      a_out_hold: assert property (p_out_hold)
        else $error("output pin changed inside hold time");
    end
  endgenerate

  // Read path
  wire sip_status_t status = '{fb_active: fb_on, baud_err: cfg_err,
                               ref_act: motion_q.ref_active,
                               abort: motion_q.motion_abort,
                               fault: fault_q,
                               finished: q_out_q[2],
                               auto_ack: q_out_q[0]};
  wire logic [IN_N-1:0] in_word = {pins_s_q.adr, pins_s_q.adr64,
                                   pins_s_q.cap_b, pins_s_q.cap_a,
                                   pins_s_q.prof_hi, pins_s_q.prof_lo,
                                   pins_s_q.baud};
  wire logic [DATA_W-1:0] rd_sel =
      (reg_addr == REG_CTRL) ? {30'h0, mode_q} :
      (reg_addr == REG_SAFETY) ? {24'h0, safety_q} :
      (reg_addr == REG_IN_WORD) ? {18'h0, in_word} :
      (reg_addr == REG_OUT_WORD) ? {27'h0, out_word_q} :
      (reg_addr == REG_OUT_SEL) ? {27'h0, out_sel_q} :
      (reg_addr == REG_BUS_CMD) ? {25'h0, 2'h0, bus_cmd_q[4:0]} :
      (reg_addr == REG_STATUS) ? {25'h0, status} :
      (reg_addr == REG_STRAP) ? {18'h0, strap_q} :
      32'h0;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      rdata_q <= '0;
    else if (reg_re)
      rdata_q <= rd_sel;
  end

  assign reg_rdata = rdata_q;
  assign q_pins = q_out_q;
  assign motion_out = motion_q;
  assign strap_out = strap_q;
  assign fieldbus_active = fb_on;
  assign fieldbus_cfg_error = cfg_err;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_sample_step;
    state_q == SIP_ST_SAMPLE && is_strap;
  endsequence
  sequence s_fclr_pin;
    is_fixed && fclr_rise && !core_in.motion_fault;
  endsequence

  property p_strap_addr;
    s_sample_step |=> strap_q.sampled &&
      strap_q.addr == $past({pins_s_q.adr64, pins_s_q.adr});
  endproperty
  a_strap_addr: assert property (p_strap_addr)
    else $error("station address not taken from straps");

  property p_strap_held;
    state_q == SIP_ST_RUN |=> $stable(strap_q);
  endproperty
  a_strap_held: assert property (p_strap_held)
    else $error("strap values changed after power-up");

  property p_baud_block;
    (strap_q.sampled && strap_q.can && strap_q.baud > CAN_BAUD_MAX) ||
    (strap_q.sampled && !strap_q.can && strap_q.baud > RS485_BAUD_MAX)
      |-> fieldbus_cfg_error && !fieldbus_active;
  endproperty
  a_baud_block: assert property (p_baud_block)
    else $error("reserved baud code left fieldbus active");

  property p_abort;
    (safe_act[SAFE_POSITIVE_TRAVEL_LIMIT] || safe_act[SAFE_NEGATIVE_TRAVEL_LIMIT] || safe_act[SAFE_STOP])
      |=> motion_out.motion_abort && !motion_out.jog_pos &&
          !motion_out.jog_neg;
  endproperty
  a_abort: assert property (p_abort)
    else $error("movement not aborted on safety input");

  property p_jog_fixed;
    is_fixed && !abort && $stable(mode_q)
      |=> motion_out.jog_pos == $past(pins_s_q.baud[0]) &&
          motion_out.jog_neg == $past(pins_s_q.baud[1]);
  endproperty
  a_jog_fixed: assert property (p_jog_fixed)
    else $error("jog command does not follow jog pins");

  property p_enable;
    is_fixed |=> motion_out.amp_enable == $past(pins_s_q.prof_lo) ||
                 !is_fixed;
  endproperty
  a_enable: assert property (p_enable)
    else $error("amplifier enable does not follow enable pin");

  property p_fault_clear;
    s_fclr_pin ##1 !core_in.motion_fault |-> !fault_q;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault indication not cleared");

  property p_capture_speed;
    $past(nrst) |-> motion_out.capture_fast == $past(is_strap);
  endproperty
  a_capture_speed: assert property (p_capture_speed)
    else $error("fast capture outside mode 0");

  property p_ref_default;
    $rose(nrst) |-> !safety_q.en[SAFE_REF];
  endproperty
  a_ref_default: assert property (p_ref_default)
    else $error("reference switch enabled after reset");

endmodule

// [sip_field_model.sv]
`timescale 1ns/1ps
module sip_field_model (
  // Clock
  input wire logic mclk,
  // Requests from the bench
  input wire sip_pkg::sip_pins_t pin_req,
  input wire sip_pkg::sip_core_t core_req,
  // Lines into the block
  output sip_pkg::sip_pins_t pins_in,
  output sip_pkg::sip_core_t core_in
);
  import sip_pkg::*;

  // Sensors idle inactive: limits and quick-stop high, everything else low
  // Switches settle just after the edge that requests them
  initial begin
    pins_in = '0;
    pins_in.lim_p = 1'b1;
    pins_in.lim_n = 1'b1;
    pins_in.qstop = 1'b1;
    core_in = '0;
    forever begin
      @(posedge mclk);
      pins_in <= pin_req;
      core_in <= core_req;
    end
  end
endmodule

// [signal_interface_pin_assign_bench.sv]
`timescale 1ns/1ps
module signal_interface_pin_assign_bench;
  import sip_pkg::*;

  logic mclk;
  logic nrst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [DATA_W-1:0] reg_rdata;
  logic [OUT_N-1:0] q_pins;
  sip_pins_t pin_cmd;
  sip_pins_t pins_in;
  sip_core_t core_cmd;
  sip_core_t core_in;
  sip_motion_t motion_out;
  sip_strap_t strap_out;
  logic fieldbus_active;
  logic fieldbus_cfg_error;
  int error_cnt;
  int comparisons;
  logic [31:0] exp_q[$];
  string name_q[$];
  logic re_d = 1'b0;
  logic [31:0] rnd;
  logic [6:0] a7;
  logic [4:0] v;
  logic [13:0] exp_strap;
  logic err;
  int n_clr;
  int n_tch;

  sip_top #(.HOLD_CYC(8), .SLOW_DIV(4), .IO_MODE_RST(2'h0)) i_dut (
    .mclk(mclk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_we(reg_we),
    .reg_re(reg_re),
    .reg_rdata(reg_rdata),
    .pins_in(pins_in),
    .q_pins(q_pins),
    .core_in(core_in),
    .motion_out(motion_out),
    .strap_out(strap_out),
    .fieldbus_active(fieldbus_active),
    .fieldbus_cfg_error(fieldbus_cfg_error)
  );

  sip_field_model i_field (
    .mclk(mclk),
    .pin_req(pin_cmd),
    .core_req(core_cmd),
    .pins_in(pins_in),
    .core_in(core_in)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Wait n edges, then let that edge's updates land
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset;
    nrst <= 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string what);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    name_q.push_back(what);
    @(posedge mclk);
    reg_re <= 1'b0;
  endtask

  // Read data stand from the cycle after the strobe until the next read strobe
  always @(posedge mclk) begin
    if (re_d === 1'b1 && exp_q.size() > 0) begin
      check(name_q.pop_front(), reg_rdata, exp_q.pop_front());
    end
    re_d <= reg_re;
  end

  initial begin
    repeat (4000) @(posedge mclk);
    error_cnt++;
    complete_run;
  end

  initial begin
    nrst = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    core_cmd = '0;
    error_cnt = 0;
    comparisons = 0;
    rnd = xs(32'h0000002D);
    a7 = rnd[6:0];
    pin_cmd = '{bus_can: 1'b1, prof_hi: 1'b0, prof_lo: 1'b1, qstop: 1'b1,
                lim_n: 1'b1, lim_p: 1'b1, ref_sw: 1'b0, adr64: a7[6],
                cap_b: 1'b0, cap_a: 1'b0, baud: 3'h5, adr: a7[5:0]};
    exp_strap = {1'b1, 1'b1, PROF_OPEN, 3'h5, a7};
    do_reset;
    cyc(10);
    check("strap", strap_out, exp_strap);
    check("fb_active", fieldbus_active, 1'b1);
    check("cap_fast", motion_out.capture_fast, 1'b1);
    check("ref_act", motion_out.ref_active, 1'b0);
    pin_cmd.adr <= ~a7[5:0];
    pin_cmd.baud <= 3'h7;
    rd(REG_SAFETY, 32'h07, "safety");
    rd(8'h20, 32'h0, "unmapped");
    rd(REG_STRAP, {18'h0, exp_strap}, "strap_reg");
    wr(REG_CTRL, 32'h3);
    rd(REG_CTRL, 32'h0, "ctrl");
    // Limit switch, active low by default
    pin_cmd.lim_p <= 1'b0;
    cyc(5);
    check("abort", motion_out.motion_abort, 1'b1);
    wr(REG_SAFETY, 32'h1F);
    cyc(3);
    check("abort_pol", motion_out.motion_abort, 1'b0);
    check("ref_en", motion_out.ref_active, 1'b1);
    // Free assignment
    wr(REG_CTRL, 32'h1);
    cyc(3);
    check("cap_slow", motion_out.capture_fast, 1'b0);
    check("strap_held", strap_out, exp_strap);
    rd(REG_IN_WORD, {18'h0, ~a7[5:0], a7[6], 4'h1, 3'h7}, "in_word");
    wr(REG_BUS_CMD, 32'h1);
    cyc(2);
    check("bus_jog", motion_out.jog_pos, 1'b1);
    rd(REG_BUS_CMD, 32'h01, "bus_cmd");
    wr(REG_BUS_CMD, 32'h0);
    rnd = xs(rnd);
    v = rnd[4:0] | 5'h01;
    wr(REG_OUT_WORD, {27'h0, v});
    cyc(3);
    check("q_first", q_pins, v);
    wr(REG_OUT_WORD, {27'h0, ~v});
    cyc(2);
    check("q_hold", q_pins, 5'h1F);
    cyc(10);
    check("q_second", q_pins, {~v});
    // Fixed assignment
    wr(REG_CTRL, 32'h2);
    pin_cmd.baud <= 3'h5;
    pin_cmd.prof_hi <= 1'b1;
    pin_cmd.prof_lo <= 1'b1;
    pin_cmd.adr64 <= 1'b0;
    core_cmd.motion_end <= 1'b1;
    cyc(5);
    check("jog_p", motion_out.jog_pos, 1'b1);
    check("jog_n", motion_out.jog_neg, 1'b0);
    check("jog_fast", motion_out.jog_fast, 1'b1);
    check("auto", motion_out.auto_mode, 1'b1);
    check("amp_en", motion_out.amp_enable, 1'b1);
    check("list_sel", motion_out.list_sel, {~a7[5:0]});
    cyc(12);
    check("auto_ack", q_pins[0], 1'b1);
    check("finished", q_pins[2], 1'b1);
    // One-cycle fault from the core latches the fault output
    core_cmd.motion_fault <= 1'b1;
    cyc(1);
    core_cmd.motion_fault <= 1'b0;
    cyc(3);
    check("fault_out", q_pins[3], 1'b1);
    rd(REG_STATUS, 32'h57, "status");
    pin_cmd.cap_a <= 1'b1;
    pin_cmd.adr64 <= 1'b1;
    n_clr = 0;
    n_tch = 0;
    repeat (8) begin
      cyc(1);
      n_clr += motion_out.fault_clear;
      n_tch += motion_out.teach_store;
    end
    check("clr_pulses", n_clr, 1);
    check("teach_pulses", n_tch, 1);
    pin_cmd.lim_p <= 1'b1;
    cyc(5);
    check("abort_fix", motion_out.motion_abort, 1'b1);
    check("jog_stop", motion_out.jog_pos, 1'b0);
    check("fault_cleared", q_pins[3], 1'b0);
    // Every baud and profile code on both buses
    for (int i = 0; i < 16; i++) begin
      pin_cmd.bus_can <= i[3];
      pin_cmd.baud <= i[2:0];
      pin_cmd.prof_hi <= i[1];
      pin_cmd.prof_lo <= i[0];
      do_reset;
      cyc(8);
      err = i[3] ? (i[2:0] > 3'h5 || i[1:0] == 2'h3) : (i[2:0] > 3'h3);
      check("cfg_error", fieldbus_cfg_error, err);
      check("fb_on", fieldbus_active, !err);
      check("baud", strap_out.baud, i[2:0]);
      if (i[3]) begin
        check("profile", strap_out.profile, i[1:0]);
      end
    end
    complete_run;
  end
endmodule
